// ==== hw/gdis_pkg.sv ====
// Behaviour
// - gates held low during any reset condition
// - high sides floating until first operating command
// - phase inputs ignored until both enables high
// - high side needs prior low-side on command
// - high-side latch set by on-then-off toggle
// - host releases reset, configures, clears, then enables
// - host drives low sides high about 1 us
// - host drives high sides low dead time plus 0.1us
// - all high sides on gives recirculation, no motion
// - toggle leaves high gate shorted, transistor off
// - high-side edge counts only after low-side toggle
// - uninitialized high side treated off, low side allowed
// - first low-side rise 280 ns after enables
// - initialized gates follow inputs until next reset, standby or fault
// - host waits 2.0 ms power-up after reset release
// - host adds 25% wait with charge pump (gdis_host waits POWER_UP_CYCLES only and never uses PUMP_UP_CYC itself)
// - enables may rise right after last transfer
// - low-side pulse 1 us, 100 ns on recovery
// - high side undefined until its toggle begins
// - normal control may follow high-side off edge
// - standby or fault: gates low, high side locked
package gdis_pkg;
  localparam int unsigned CLK_MHZ          = 20;
  localparam int unsigned PHASES           = 3;
  localparam int unsigned POWER_UP_US      = 2000;
  localparam int unsigned PUMP_EXTRA_PCT   = 25;
  localparam int unsigned ENABLE_TO_LS_NS  = 280;
  localparam int unsigned LS_PULSE_NS      = 1000;
  localparam int unsigned LS_RECOVERY_NS   = 100;
  localparam int unsigned HS_MARGIN_NS     = 100;
  // least times round up to whole cycles
  localparam int unsigned POWER_UP_CYC     = POWER_UP_US * CLK_MHZ;
  localparam int unsigned PUMP_UP_CYC      = POWER_UP_CYC + (POWER_UP_CYC * PUMP_EXTRA_PCT + 99) / 100;
  localparam int unsigned ENABLE_TO_LS_CYC = (ENABLE_TO_LS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LS_PULSE_CYC     = (LS_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LS_RECOVERY_CYC  = (LS_RECOVERY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HS_MARGIN_CYC    = (HS_MARGIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DEAD_CYC_DEFAULT = 2;
  // per-phase initialization state
  typedef enum logic [1:0] {
    GDIS_UNINIT,
    GDIS_LS_TOGGLED,
    GDIS_HS_ON_SEEN,
    GDIS_HS_LATCHED
  } gdis_phase_e;
endpackage : gdis_pkg

// ==== hw/gdis_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// pins between host controller and pre-driver sequencer
interface gdis_link_if;
  logic       reset_n;
  logic       enable_one_pin;
  logic       enable_two_pin;
  logic [2:0] low_side_in;     // phase a,b,c low-side commands
  logic [2:0] high_side_in_n;  // phase a,b,c high-side commands, low = on
  modport device (
    input reset_n,
    input enable_one_pin,
    input enable_two_pin,
    input low_side_in,
    input high_side_in_n
  );
  modport host (
    output reset_n,
    output enable_one_pin,
    output enable_two_pin,
    output low_side_in,
    output high_side_in_n
  );
endinterface : gdis_link_if
`default_nettype wire

// ==== hw/gdis_device.sv ====
`timescale 1ns/1ps
`default_nettype none
// pre-driver end: per-phase init tracking and gate drive
module gdis_device
  import gdis_pkg::*;
#(
  parameter int unsigned N = gdis_pkg::PHASES
) (
  input  wire logic      clk_in,
  input  wire logic      srst_in,
  gdis_link_if.device    link,
  input  wire logic      low_side_supply_ok_in,
  input  wire logic      logic_supply_ok_in,
  input  wire logic      standby_in,
  input  wire logic      fault_in,
  output logic [N-1:0]   low_gate_out,
  output logic [N-1:0]   high_gate_out,
  output logic [N-1:0]   high_gate_drive_en_out,
  output logic [N-1:0]   high_latched_out,
  output logic           hold_off_out
);
  import gdis_pkg::*;

  logic        hold_off;
  logic        enabled;
  logic [N-1:0] ls_reg;
  logic [N-1:0] hs_n_reg;
  gdis_phase_e  st_reg [N];

  // any reset condition holds every gate low
  assign hold_off = srst_in | ~link.reset_n | ~low_side_supply_ok_in | ~logic_supply_ok_in;
  assign enabled  = link.enable_one_pin & link.enable_two_pin & ~standby_in;
  assign hold_off_out = hold_off;

  // previous input levels for edge detection
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ls_reg   <= '0;
      hs_n_reg <= '1;
    end else begin
      ls_reg   <= link.low_side_in;
      hs_n_reg <= link.high_side_in_n;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_phase
      logic ls_rise;
      logic ls_fall;
      logic hs_fall;
      logic hs_rise;
      assign ls_rise = link.low_side_in[g] & ~ls_reg[g];
      assign ls_fall = ~link.low_side_in[g] & ls_reg[g];
      assign hs_fall = ~link.high_side_in_n[g] & hs_n_reg[g];
      assign hs_rise = link.high_side_in_n[g] & ~hs_n_reg[g];

      // init sequence; reset, standby and fault drop back to uninit
      always_ff @(posedge clk_in) begin
        if (hold_off || standby_in || fault_in) begin
          st_reg[g] <= GDIS_UNINIT;
        end else if (enabled) begin
          case (st_reg[g])
            GDIS_UNINIT:     if (ls_rise) st_reg[g] <= GDIS_LS_TOGGLED;
            // high edge counts once the low side is off; falling together is legal (no gap needed)
            GDIS_LS_TOGGLED: if (hs_fall && !link.low_side_in[g]) st_reg[g] <= GDIS_HS_ON_SEEN;
            GDIS_HS_ON_SEEN: if (hs_rise) st_reg[g] <= GDIS_HS_LATCHED;
            GDIS_HS_LATCHED: st_reg[g] <= GDIS_HS_LATCHED;
            default:         st_reg[g] <= GDIS_UNINIT;
          endcase
        end
      end

      // gate outputs registered; low side allowed even if high side never latched
      always_ff @(posedge clk_in) begin
        if (hold_off || standby_in || fault_in || !enabled) begin
          low_gate_out[g]           <= 1'b0;
          high_gate_out[g]          <= 1'b0;
          high_gate_drive_en_out[g] <= 1'b0;
          high_latched_out[g]       <= 1'b0;
        end else begin
          low_gate_out[g]           <= link.low_side_in[g];
          // on-pulse of the toggle drives the gate; all three on = recirculation
          high_gate_out[g]          <= (st_reg[g] == GDIS_HS_LATCHED || st_reg[g] == GDIS_HS_ON_SEEN)
                                       & ~link.high_side_in_n[g];
          // out of tri-state from the toggle's on edge: gate held to source while off
          high_gate_drive_en_out[g] <= (st_reg[g] == GDIS_HS_LATCHED) ||
                                       (st_reg[g] == GDIS_HS_ON_SEEN);
          high_latched_out[g]       <= (st_reg[g] == GDIS_HS_LATCHED);
        end
      end
    end
  endgenerate
endmodule // gdis_device
`default_nettype wire

// ==== hw/gdis_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// controller end: plays the power-up and init sequence, then passes commands
module gdis_host
  import gdis_pkg::*;
#(
  parameter int unsigned POWER_UP_CYCLES = gdis_pkg::POWER_UP_CYC,
  parameter int unsigned DEAD_CYCLES     = gdis_pkg::DEAD_CYC_DEFAULT
) (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  gdis_link_if.host        link,
  input  wire logic        start_in,
  input  wire logic        recovery_in,
  input  wire logic        config_done_in,
  input  wire logic [2:0]  low_cmd_in,
  input  wire logic [2:0]  high_cmd_n_in,
  output logic             busy_out,
  output logic             ready_out
);
  import gdis_pkg::*;

  typedef enum logic [2:0] {
    GDIS_H_IDLE, GDIS_H_POWER, GDIS_H_CONFIG, GDIS_H_EN_WAIT,
    GDIS_H_LS_ON, GDIS_H_HS_ON, GDIS_H_RUN
  } gdis_host_e;

  gdis_host_e  state_reg;
  logic [31:0] cnt_reg;
  logic        rec_reg;

  // sequence: reset release, wait, config, enables, ls pulse, hs toggle
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= GDIS_H_IDLE;
      cnt_reg   <= '0;
      rec_reg   <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      case (state_reg)
        GDIS_H_IDLE: if (start_in) begin
          state_reg <= recovery_in ? GDIS_H_CONFIG : GDIS_H_POWER;
          rec_reg   <= recovery_in;
          cnt_reg   <= '0;
        end
        // power-up wait; longer figure belongs in the parameter
        GDIS_H_POWER: if (cnt_reg >= POWER_UP_CYCLES - 1) begin
          state_reg <= GDIS_H_CONFIG;
        end
        GDIS_H_CONFIG: if (config_done_in) begin
          state_reg <= GDIS_H_EN_WAIT;
          cnt_reg   <= '0;
        end
        GDIS_H_EN_WAIT: if (cnt_reg >= ENABLE_TO_LS_CYC - 1) begin
          state_reg <= GDIS_H_LS_ON;
          cnt_reg   <= '0;
        end
        GDIS_H_LS_ON: if (cnt_reg >= (rec_reg ? LS_RECOVERY_CYC : LS_PULSE_CYC) - 1) begin
          state_reg <= GDIS_H_HS_ON;
          cnt_reg   <= '0;
        end
        GDIS_H_HS_ON: if (cnt_reg >= DEAD_CYCLES + HS_MARGIN_CYC - 1) begin
          state_reg <= GDIS_H_RUN;
        end
        GDIS_H_RUN: state_reg <= GDIS_H_RUN;
        default:    state_reg <= GDIS_H_IDLE;
      endcase
    end
  end

  // pin drive follows state; all high sides toggle together
  always_comb begin
    link.reset_n        = (state_reg != GDIS_H_IDLE) || rec_reg;
    link.enable_one_pin = (state_reg == GDIS_H_EN_WAIT) || (state_reg == GDIS_H_LS_ON) ||
                          (state_reg == GDIS_H_HS_ON) || (state_reg == GDIS_H_RUN);
    link.enable_two_pin = link.enable_one_pin;
    link.low_side_in    = (state_reg == GDIS_H_LS_ON) ? 3'h7 :
                          (state_reg == GDIS_H_RUN) ? low_cmd_in : 3'h0;
    link.high_side_in_n = (state_reg == GDIS_H_HS_ON) ? 3'h0 :
                          (state_reg == GDIS_H_RUN) ? high_cmd_n_in : 3'h7;
  end

  assign busy_out  = (state_reg != GDIS_H_IDLE) && (state_reg != GDIS_H_RUN);
  assign ready_out = (state_reg == GDIS_H_RUN);
endmodule // gdis_host
`default_nettype wire

// ==== sim/gdis_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// watches both ends of the link plus the gate outputs
module gdis_properties (
  input wire logic       clk_in,
  input wire logic       srst_in,
  input wire logic       reset_n,
  input wire logic       enable_one_pin,
  input wire logic       enable_two_pin,
  input wire logic [2:0] low_side_in,
  input wire logic [2:0] high_side_in_n,
  input wire logic       low_side_supply_ok_in,
  input wire logic       logic_supply_ok_in,
  input wire logic       standby_in,
  input wire logic       fault_in,
  input wire logic [2:0] low_gate_out,
  input wire logic [2:0] high_gate_out,
  input wire logic [2:0] high_gate_drive_en_out,
  input wire logic [2:0] high_latched_out,
  input wire logic       hold_off_out
);
  // one domain, so clock and disable are shared
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  property p_hold; hold_off_out == (!reset_n || !low_side_supply_ok_in || !logic_supply_ok_in); endproperty
  a_hold: assert property (p_hold) else $error("hold-off level wrong");
  property p_hold_low; hold_off_out |=> low_gate_out == 3'h0 && high_gate_drive_en_out == 3'h0; endproperty
  a_hold_low: assert property (p_hold_low) else $error("gates not low in hold-off");
  property p_en_low; !(enable_one_pin && enable_two_pin) |=> (low_gate_out | high_gate_out) == 3'h0; endproperty
  a_en_low: assert property (p_en_low) else $error("gate moved while disabled");
  property p_drv; $rose(high_gate_drive_en_out[0]) |-> !$past(high_side_in_n[0]) || !$past(high_side_in_n[0], 2);
  endproperty
  a_drv: assert property (p_drv) else $error("high driver left tri-state without on command");
  property p_lat; $rose(high_latched_out[0]) |-> high_gate_drive_en_out[0] && $past(high_side_in_n[0]); endproperty
  a_lat: assert property (p_lat) else $error("latch set without toggle");
  property p_follow; enable_one_pin && enable_two_pin && !hold_off_out && !standby_in && !fault_in
    |=> low_gate_out == $past(low_side_in); endproperty
  a_follow: assert property (p_follow) else $error("low gate not following input");
  property p_standby_state; standby_in |=> (low_gate_out | high_gate_drive_en_out | high_latched_out) == 3'h0; endproperty
  a_standby_state: assert property (p_standby_state) else $error("standby did not lock high side");
  property p_flt; fault_in ##1 !fault_in |-> (high_latched_out == 3'h0) [*2]; endproperty
  a_flt: assert property (p_flt) else $error("fault did not clear latch");
endmodule // gdis_properties
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gdis_pkg::*;
  logic clk_in = 0, srst_in = 1, start = 0, rec = 0, cfg = 0, lss = 1, lgs = 1, standby_state = 0, flt = 0, rdy, busy;
  logic [2:0] lcmd = 0, hcmd = 3'h7, lg, hg, hen, hlat, l, h;
  logic hold;
  int n_mismatch = 0, tests_run = 0, lat = 0, i, k, n_ls = 0, n_hs = 0;
  gdis_link_if gdis_link_if_i ();
  gdis_host #(.POWER_UP_CYCLES(10)) gdis_host_i (.clk_in(clk_in), .srst_in(srst_in), .link(gdis_link_if_i),
    .start_in(start), .recovery_in(rec), .config_done_in(cfg), .low_cmd_in(lcmd), .high_cmd_n_in(hcmd),
    .busy_out(busy), .ready_out(rdy));
  gdis_device gdis_device_i (.clk_in(clk_in), .srst_in(srst_in), .link(gdis_link_if_i),
    .low_side_supply_ok_in(lss), .logic_supply_ok_in(lgs), .standby_in(standby_state), .fault_in(flt),
    .low_gate_out(lg), .high_gate_out(hg), .high_gate_drive_en_out(hen), .high_latched_out(hlat),
    .hold_off_out(hold));
  gdis_properties gdis_properties_i (.clk_in(clk_in), .srst_in(srst_in), .reset_n(gdis_link_if_i.reset_n),
    .enable_one_pin(gdis_link_if_i.enable_one_pin), .enable_two_pin(gdis_link_if_i.enable_two_pin),
    .low_side_in(gdis_link_if_i.low_side_in), .high_side_in_n(gdis_link_if_i.high_side_in_n),
    .low_side_supply_ok_in(lss), .logic_supply_ok_in(lgs), .standby_in(standby_state), .fault_in(flt),
    .low_gate_out(lg), .high_gate_out(hg), .high_gate_drive_en_out(hen), .high_latched_out(hlat),
    .hold_off_out(hold));
  // 20 MHz clock
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // wait for the host to finish its walk, counting pulse widths seen on the link
  task automatic wait_ready;
    i = 0;
    n_ls = 0;
    n_hs = 0;
    while (rdy !== 1'b1 && i < 300) begin
      @(posedge clk_in);
      i++;
      if (gdis_link_if_i.low_side_in === 3'h7) n_ls++;
      if (gdis_link_if_i.high_side_in_n === 3'h0) n_hs++;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // cut a hang short; the whole run needs well under 1000 cycles
  initial begin
    repeat (3000) @(posedge clk_in);
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h2FC12BDD));
    repeat (20) @(posedge clk_in);
    chk("hold", {2'h0, hold}, 3'h1);
    chk("gate", lg | hen, 3'h0);
    srst_in <= 0;
    start <= 1;
    repeat (20) @(posedge clk_in);
    chk("tri", hen, 3'h0);
    chk("busy", {2'h0, busy}, 3'h1);
    cfg <= 1;
    wait_ready;
    chk("lspulse", n_ls, LS_PULSE_CYC);
    chk("hspulse", n_hs, DEAD_CYC_DEFAULT + HS_MARGIN_CYC);
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    lat = 7;
    chk("rdy", {2'h0, rdy}, 3'h1);
    chk("lat", hlat, lat[2:0]);
    chk("drv", hen, 3'h7);
    chk("hoff", hg, 3'h0);
    chk("idle", {2'h0, busy}, 3'h0);
    // random commands, last one all high sides on
    for (k = 0; k <= 16; k++) begin
      @(posedge clk_in);
      l = (k == 16) ? 3'h0 : 3'($urandom);
      h = (k == 16) ? 3'h7 : 3'($urandom) & ~l; // never both sides of one phase
      lcmd <= l;
      hcmd <= ~h;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk("low", lg, l);
      chk("high", hg, h);
    end
    // standby then fault: high side locked out until re-init
    for (k = 0; k < 2; k++) begin
      @(posedge clk_in);
      standby_state <= (k == 0);
      flt <= (k == 1);
      repeat (2) @(posedge clk_in);
      standby_state <= 0;
      flt <= 0;
      lat = 0;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk("lock", hen | hlat, lat[2:0]);
    end
    // mid-run reset, then the short recovery walk that skips the power-up wait
    @(posedge clk_in);
    srst_in <= 1;
    start <= 0;
    rec <= 1;
    lcmd <= 3'h0;
    hcmd <= 3'h7;
    repeat (2) @(posedge clk_in);
    srst_in <= 0;
    start <= 1;
    @(negedge clk_in);
    chk("rst", hlat | hen | lg, 3'h0);
    wait_ready;
    chk("rlspulse", n_ls, LS_RECOVERY_CYC);
    chk("rhspulse", n_hs, DEAD_CYC_DEFAULT + HS_MARGIN_CYC);
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk("rrdy", {2'h0, rdy}, 3'h1);
    chk("rlat", hlat, 3'h7);
    chk("rdrv", hen, 3'h7);
    @(posedge clk_in);
    lss <= 0;
    lcmd <= 3'h7;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk("hold", {2'h0, hold}, 3'h1);
    chk("lsup", lg, 3'h0);
    // logic supply low holds the gates as well
    @(posedge clk_in);
    lss <= 1;
    lgs <= 0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk("lghold", {2'h0, hold}, 3'h1);
    chk("lgsup", lg, 3'h0);
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
